// [smcb_bank.sv]
`timescale 1ns/1ns
// ********************
// misc control bank
// ********************
module smcb_bank
  import smcb_pkg::*;
#(
  parameter int PAUSE_CYCLES = PAUSE_LIMIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic port1CopperLink,
  input wire logic port1HostLink,
  input wire logic port2CopperLink,
  input wire logic port3HostLink,
  input wire logic pauseActive,
  output logic flowControlOffReq,
  output logic intOut,
  output logic port1FibreHighThreshold,
  output logic port2FibreHighThreshold,
  output logic regulatorOff,
  output logic [5:0] insertDefaultVlan,
  output logic hostClockOff,
  output logic coreClockOff,
  output logic pllOff,
  output smcb_pm_t powerMode,
  input wire logic linkAct,
  input wire logic linkOnly,
  input wire logic activity,
  input wire logic speed,
  input wire logic duplex,
  input wire logic energyDetectStretched,
  input wire logic deviceReady,
  output logic firstIndicatorPin,
  output logic secondIndicatorPin
);
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] pause;
    logic [7:0] fibre;
    logic [7:0] regc;
    logic [7:0] vlan;
    logic [7:0] pwr;
    logic [31:0] pauseCount;
    logic offReq;
    logic [7:0] rdata;
    logic ind0;
    logic ind1;
  } smcb_state_t;

  smcb_state_t st;
  smcb_state_t next_st;
  logic [3:0] linkLevel;
  logic [3:0] change;
  logic [7:0] events;
  logic [7:0] clearBits;
  logic [3:0] flagBits;
  logic [7:0] statusBits;
  logic n0;
  logic n1;

  // ********************
  // link watchers
  // ********************
  assign linkLevel = {port3HostLink, port2CopperLink, port1HostLink, port1CopperLink};

  smcb_link_watch smcb_link_watch_p1copper (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .linkIn(linkLevel[0]),
    .linkChange(change[0])
  );

  smcb_link_watch smcb_link_watch_p1host (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .linkIn(linkLevel[1]),
    .linkChange(change[1])
  );

  smcb_link_watch smcb_link_watch_p2copper (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .linkIn(linkLevel[2]),
    .linkChange(change[2])
  );

  smcb_link_watch smcb_link_watch_p3host (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .linkIn(linkLevel[3]),
    .linkChange(change[3])
  );
  // ********************
  // status flags
  // ********************
  smcb_event_flag smcb_event_flag_p12 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .setEvent(events[BIT_P12]),
    .clearReq(clearBits[BIT_P12]),
    .flag(flagBits[3])
  );

  smcb_event_flag smcb_event_flag_p3 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .setEvent(events[BIT_P3]),
    .clearReq(clearBits[BIT_P3]),
    .flag(flagBits[2])
  );

  smcb_event_flag smcb_event_flag_p2 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .setEvent(events[BIT_P2]),
    .clearReq(clearBits[BIT_P2]),
    .flag(flagBits[1])
  );

  smcb_event_flag smcb_event_flag_p1 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .setEvent(events[BIT_P1]),
    .clearReq(clearBits[BIT_P1]),
    .flag(flagBits[0])
  );
  assign statusBits = {flagBits[3], 4'h0, flagBits[2], flagBits[1], flagBits[0]};

  // ********************
  // next state
  // ********************
  always_comb begin
    next_st = st;
    // ********************
    // link events
    // ********************
    events = 8'h00;
    events[BIT_P12] = change[0] | change[2];
    events[BIT_P3] = change[3];
    events[BIT_P2] = change[2];
    events[BIT_P1] = change[0] | change[1];
    clearBits = 8'h00;
    if (regWrite && regAddr == ADDR_STATUS) begin
      clearBits = regWdata;
    end
    // ********************
    // register writes
    // ********************
    if (regWrite) begin
      if (regAddr == ADDR_MASK) begin
        next_st.mask = regWdata;
      end else if (regAddr == ADDR_PAUSE) begin
        next_st.pause = regWdata;
      end else if (regAddr == ADDR_FIBRE) begin
        next_st.fibre = regWdata & FIBRE_USED;
      end else if (regAddr == ADDR_REG) begin
        next_st.regc = regWdata & REG_USED;
      end else if (regAddr == ADDR_VLAN) begin
        next_st.vlan = regWdata & VLAN_USED;
      end else if (regAddr == ADDR_PWR) begin
        next_st.pwr = regWdata;
      end
    end
    // ********************
    // pause timer
    // ********************
    if (st.pause != 8'h00 && pauseActive) begin
      if (st.pauseCount >= PAUSE_CYCLES - 1) begin
        next_st.offReq = 1'b1;
      end else begin
        next_st.pauseCount = st.pauseCount + 32'h00000001;
      end
    end else begin
      next_st.pauseCount = 32'h00000000;
      next_st.offReq = 1'b0;
    end
    // ********************
    // read mux
    // ********************
    if (regAddr == ADDR_Q1_SPLIT) begin
      next_st.rdata = Q1_SPLIT_VALUE;
    end else if (regAddr == ADDR_Q0_SPLIT) begin
      next_st.rdata = Q0_SPLIT_VALUE;
    end else if (regAddr == ADDR_MASK) begin
      next_st.rdata = st.mask;
    end else if (regAddr == ADDR_STATUS) begin
      next_st.rdata = statusBits;
    end else if (regAddr == ADDR_PAUSE) begin
      next_st.rdata = st.pause;
    end else if (regAddr == ADDR_FIBRE) begin
      next_st.rdata = st.fibre;
    end else if (regAddr == ADDR_REG) begin
      next_st.rdata = st.regc;
    end else if (regAddr == ADDR_VLAN) begin
      next_st.rdata = st.vlan;
    end else if (regAddr == ADDR_PWR) begin
      next_st.rdata = st.pwr;
    end else begin
      next_st.rdata = 8'h00;
    end
    if (!regRead) begin
      next_st.rdata = st.rdata;
    end
    // ********************
    // indicator pins
    // ********************
    case (st.pwr[BIT_IND_MODE_HI:BIT_IND_MODE_LO])
      2'b00: begin
        n0 = linkAct;
        n1 = speed;
      end
      2'b01: begin
        n0 = linkOnly;
        n1 = activity;
      end
      2'b10: begin
        n0 = linkAct;
        n1 = duplex;
      end
      default: begin
        n0 = linkOnly;
        n1 = duplex;
      end
    endcase
    if (st.pwr[BIT_IND_DEBUG]) begin
      next_st.ind0 = ~deviceReady;
      next_st.ind1 = ~energyDetectStretched;
    end else begin
      next_st.ind0 = n0;
      next_st.ind1 = n1;
    end
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ********************
  // outputs
  // ********************
  assign regRdata = st.rdata;
  assign intOut = |(statusBits & st.mask);
  assign flowControlOffReq = st.offReq;
  assign port2FibreHighThreshold = st.fibre[7];
  assign port1FibreHighThreshold = st.fibre[6];
  assign regulatorOff = st.regc[BIT_REG_OFF];
  assign insertDefaultVlan = st.vlan[5:0];
  assign hostClockOff = st.pwr[BIT_HOSTCLK_OFF];
  assign coreClockOff = st.pwr[BIT_CORECLK_OFF];
  assign pllOff = st.pwr[BIT_PLL_OFF];
  assign powerMode = smcb_pm_t'(st.pwr[1:0]);
  assign firstIndicatorPin = st.ind0;
  assign secondIndicatorPin = st.ind1;
endmodule // smcb_bank

// ********************
// link watcher
// ********************
module smcb_link_watch
  import smcb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic linkIn,
  output logic linkChange
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [1:0] warm;
  } smcb_watch_t;

  smcb_watch_t st;
  smcb_watch_t next_st;

  // ********************
  // next state
  // ********************
  always_comb begin
    next_st = st;
    next_st.sync1 = linkIn;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    if (st.warm != LINK_WARM_DONE) begin
      next_st.warm = st.warm + 2'h1;
    end
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ********************
  // outputs
  // ********************
  assign linkChange = (st.warm == LINK_WARM_DONE) && (st.sync2 != st.prev);
endmodule // smcb_link_watch

// ********************
// sticky event flag
// ********************
module smcb_event_flag
  import smcb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic setEvent,
  input wire logic clearReq,
  output logic flag
);
  typedef struct packed {
    logic flag;
  } smcb_flag_t;

  smcb_flag_t st;
  smcb_flag_t next_st;

  // ********************
  // next state
  // ********************
  always_comb begin
    next_st = st;
    if (setEvent) begin
      next_st.flag = 1'b1;
    end else if (clearReq) begin
      next_st.flag = 1'b0;
    end
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ********************
  // outputs
  // ********************
  assign flag = st.flag;
endmodule // smcb_event_flag

// [smcb_pkg.sv]
package smcb_pkg;
  localparam logic [7:0] ADDR_Q1_SPLIT = 8'hB9;
  localparam logic [7:0] ADDR_Q0_SPLIT = 8'hBA;
  localparam logic [7:0] ADDR_MASK = 8'hBB;
  localparam logic [7:0] ADDR_STATUS = 8'hBC;
  localparam logic [7:0] ADDR_PAUSE = 8'hBD;
  localparam logic [7:0] ADDR_FIBRE = 8'hC0;
  localparam logic [7:0] ADDR_REG = 8'hC1;
  localparam logic [7:0] ADDR_VLAN = 8'hC2;
  localparam logic [7:0] ADDR_PWR = 8'hC3;
  localparam logic [7:0] Q1_SPLIT_VALUE = 8'h82;
  localparam logic [7:0] Q0_SPLIT_VALUE = 8'h81;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] STATUS_USED = 8'h87;
  localparam logic [7:0] FIBRE_USED = 8'hC0;
  localparam logic [7:0] REG_USED = 8'h40;
  localparam logic [7:0] VLAN_USED = 8'h3F;
  localparam int BIT_P12 = 7;
  localparam int BIT_P3 = 2;
  localparam int BIT_P2 = 1;
  localparam int BIT_P1 = 0;
  localparam int BIT_HOSTCLK_OFF = 7;
  localparam int BIT_CORECLK_OFF = 6;
  localparam int BIT_IND_MODE_HI = 5;
  localparam int BIT_IND_MODE_LO = 4;
  localparam int BIT_IND_DEBUG = 3;
  localparam int BIT_PLL_OFF = 2;
  localparam int BIT_REG_OFF = 6;
  localparam int PAUSE_LIMIT_MS = 160;
  localparam int CLK_MHZ = 100;
  localparam int PAUSE_LIMIT_CYCLES = PAUSE_LIMIT_MS * 1000 * CLK_MHZ;
  localparam logic [1:0] LINK_WARM_DONE = 2'h3;
  typedef enum logic [1:0] {PM_NORMAL, PM_ENERGY, PM_SOFT_DOWN, PM_SAVING} smcb_pm_t;
endpackage

// [smcb_props.sv]
`timescale 1ns/1ns
// ****
// checks
// ****
module smcb_props
  import smcb_pkg::*;
#(
  parameter int PAUSE_CYCLES = PAUSE_LIMIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic pauseActive,
  input wire logic flowControlOffReq,
  input wire logic intOut,
  input wire logic port1FibreHighThreshold,
  input wire logic port2FibreHighThreshold,
  input wire logic [5:0] insertDefaultVlan
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  a_pause_drop: assert property (!pauseActive |=> !flowControlOffReq)
    else $error("flow off request without pause");
  a_pause_wait: assert property ($rose(pauseActive) |-> !flowControlOffReq[*8])
    else $error("flow off request too early");
  a_fibre_write: assert property (regWrite && regAddr == ADDR_FIBRE |=>
    {port2FibreHighThreshold, port1FibreHighThreshold} == $past(regWdata[7:6]))
    else $error("fibre select wrong");
  a_vlan_write: assert property (regWrite && regAddr == ADDR_VLAN |=>
    insertDefaultVlan == $past(regWdata[5:0]))
    else $error("vlan insert wrong");
  a_q1_read: assert property (regRead && regAddr == ADDR_Q1_SPLIT |=>
    regRdata == Q1_SPLIT_VALUE)
    else $error("q1 split wrong");
  a_q0_read: assert property (regRead && regAddr == ADDR_Q0_SPLIT |=>
    regRdata == Q0_SPLIT_VALUE)
    else $error("q0 split wrong");
  a_unmapped_read: assert property (regRead && regAddr == 8'h00 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_int_masked: assert property (regWrite && regAddr == ADDR_MASK && regWdata == 8'h00 |=>
    !intOut)
    else $error("interrupt while masked");
  c_pause: cover property ($rose(flowControlOffReq));
  c_int: cover property ($rose(intOut));
  c_fibre: cover property (port2FibreHighThreshold && port1FibreHighThreshold);
endmodule // smcb_props

// [tb_top.sv]
`timescale 1ns/1ns
// ****
// bench
// ****
module tb_top;
  import smcb_pkg::*;
  logic clk_sys = 1'h0, sys_rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, pauseActive = 1'h0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic [3:0] lk = 4'h0;
  wire logic port1CopperLink = lk[0], port1HostLink = lk[1];
  wire logic port2CopperLink = lk[2], port3HostLink = lk[3];
  logic linkAct = 1'h1, linkOnly = 1'h0, activity = 1'h0, speed = 1'h0, duplex = 1'h1;
  logic energyDetectStretched = 1'h0, deviceReady = 1'h1;
  logic flowControlOffReq, intOut, port1FibreHighThreshold, port2FibreHighThreshold;
  logic regulatorOff, hostClockOff, coreClockOff, pllOff, firstIndicatorPin, secondIndicatorPin;
  logic [5:0] insertDefaultVlan;
  smcb_pm_t powerMode;
  wire logic [7:0] ctl = {hostClockOff, coreClockOff, pllOff, powerMode,
    port1FibreHighThreshold, port2FibreHighThreshold, regulatorOff};
  wire logic [7:0] pv = {4'h0, powerMode, firstIndicatorPin, secondIndicatorPin};
  int fails = 0, cmp_count = 0;
  logic [7:0] ra[7] = '{ADDR_MASK, ADDR_STATUS, ADDR_PAUSE, ADDR_FIBRE, ADDR_REG, ADDR_VLAN, ADDR_PWR};
  logic [7:0] rm[7] = '{8'hFF, 8'h00, 8'hFF, 8'hC0, 8'h40, 8'h3F, 8'hFD};
  logic [7:0] st[4] = '{8'h81, 8'h01, 8'h82, 8'h04};
  logic [1:0] pe[4] = '{2'h2, 2'h0, 2'h3, 2'h1};
  localparam int PAUSE_SIM = 20;
  smcb_bank #(.PAUSE_CYCLES(PAUSE_SIM)) smcb_bank_inst (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'h0;
    @(negedge clk_sys);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'h0;
    @(negedge clk_sys);
    chk("regRdata", e, regRdata);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(ADDR_Q1_SPLIT, Q1_SPLIT_VALUE);
    wr(ADDR_Q0_SPLIT, Q0_SPLIT_VALUE);
    rd(ADDR_Q0_SPLIT, Q0_SPLIT_VALUE);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], 8'h00);
      wr(ra[i], rm[i]);
      rd(ra[i], rm[i]);
    end
    chk("ctl", 8'hEF, ctl);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_PWR, 8'(m * 8'h11) & 8'h33);
      @(negedge clk_sys);
      chk("pins", {4'h0, m[1:0], pe[m]}, pv);
    end
    wr(ADDR_PWR, 8'h08);
    @(negedge clk_sys);
    chk("pins", 8'h01, pv);
    wr(ADDR_MASK, 8'h04);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      lk[i] <= 1'h1;
      repeat (6) @(negedge clk_sys);
      chk("intOut", {7'h0, i == 3}, {7'h0, intOut});
      rd(ADDR_STATUS, st[i]);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, st[i]);
      wr(ADDR_STATUS, st[i]);
      rd(ADDR_STATUS, 8'h00);
      chk("intOut", 8'h00, {7'h0, intOut});
    end
    wr(ADDR_MASK, 8'h00);
    @(posedge clk_sys);
    pauseActive <= 1'h1;
    repeat (PAUSE_SIM) @(negedge clk_sys);
    chk("flowOff", 8'h00, {7'h0, flowControlOffReq});
    @(negedge clk_sys);
    chk("flowOff", 8'h01, {7'h0, flowControlOffReq});
    wr(ADDR_PAUSE, 8'h00);
    repeat (PAUSE_SIM + 2) @(negedge clk_sys);
    chk("flowOff", 8'h00, {7'h0, flowControlOffReq});
    wr(ADDR_PAUSE, 8'h01);
    repeat (PAUSE_SIM + 2) @(negedge clk_sys);
    chk("flowOff", 8'h01, {7'h0, flowControlOffReq});
    @(posedge clk_sys);
    pauseActive <= 1'h0;
    repeat (2) @(negedge clk_sys);
    chk("flowOff", 8'h00, {7'h0, flowControlOffReq});
    final_report();
  end
endmodule // tb_top
bind smcb_bank smcb_props #(.PAUSE_CYCLES(PAUSE_CYCLES)) smcb_props_inst (.*);
